// file: hw/timer2_capture_reload_counter.sv
// timer two: 16-bit capture / auto-reload / baud clock counter behind the sfr port
//
// Contract
// - Timer function increments the 16-bit count once per twelve-period machine cycle.
// - Counter function samples count pin per machine cycle; counts a high-then-low pair.
// - Incremented value shows in the machine cycle after the detecting one.
// - External events counted at most once per twenty-four oscillator periods.
// - Run clear is off; serial selects give baud mode; else capture or reload.
// - Overflow flag set on overflow, cleared by software, never in baud mode.
// - External flag set by enabled trigger edge capture or reload; software clears it.
// - Interrupt request from flags when enabled; external flag silent in up/down mode.
// - Receive clock select picks this overflow, else the other timer's overflow.
// - Transmit clock select picks this overflow, else the other timer's overflow.
// - Trigger enable lets edges capture or reload, not while clocking the serial port.
// - Run control starts the timer when one, stops it when zero.
// - Count source select: zero machine-cycle timing, one external falling edges.
// - Capture select one captures on edges; zero reloads on overflow and edges.
// - In baud mode capture select is ignored and overflow always reloads.
// - Capture mode: edge copies count to capture pair and sets external flag.
// - Up/down enable resets to zero; when set trigger pin level gives direction.
// - Up-only reload mode counts to 0ffffh and flags the overflow.
// - Auto-reload loads the capture/reload pair into the count.
// - Down count underflows at reload pair, flags it and loads 0ffffh.
// - In up/down mode external flag toggles on each wrap, as a seventeenth bit.
// - Baud mode with internal timing increments every state time, two periods.
`timescale 1ns/1ps
`default_nettype none

module timer2_capture_reload_counter
    import timer2_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    output logic [7:0] sfr_rdata,
    input wire logic external_count_input,
    input wire logic trigger_direction_pin,
    input wire logic timer_irq_enable,
    input wire logic other_timer_overflow,
    output logic timer_irq,
    output logic rx_clock_tick,
    output logic tx_clock_tick
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // baud clock generation is selected by either serial clock select
    function automatic logic baud_sel(input logic [7:0] c);
        baud_sel = c[RCLK_BIT] | c[TRANSMIT_CLOCK_SELECT_BIT];
    endfunction

    // up/down counting applies only in plain auto-reload mode
    function automatic logic updn_sel(input logic [7:0] c, input logic [1:0] m);
        updn_sel = m[UPDN_BIT] & ~baud_sel(c) & ~c[CPRL_BIT];
    endfunction

    // read view of one register; unmapped addresses read as zero
    function automatic logic [7:0] read_mux(input logic [7:0] a, input timer2_state_t s);
        case (a)
            CTRL_ADDR: begin
                read_mux = s.ctrl;
            end
            MODE_ADDR: begin
                read_mux = {6'h00, s.mode};
            end
            RELOAD_LO_ADDR: begin
                read_mux = s.reload[7:0];
            end
            RELOAD_HI_ADDR: begin
                read_mux = s.reload[15:8];
            end
            COUNT_LO_ADDR: begin
                read_mux = s.count[7:0];
            end
            COUNT_HI_ADDR: begin
                read_mux = s.count[15:8];
            end
            default: begin
                read_mux = 8'h00;
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    timer2_state_t st_r;
    timer2_state_t st_nxt;

    // machine cycle strobes
    logic phase_last;
    logic sample_now;
    logic update_now;
    logic state_tick;

    // mode decode
    logic baud;
    logic updn;
    logic run;

    // counting events
    logic cnt_edge;
    logic trg_edge;
    logic tick;
    logic trig;
    logic down;
    logic at_max;
    logic at_reload;
    logic ovf;
    logic unf;
    logic wrap;
    logic own_tick;
    logic irq_src;

    // combinational next value of every field
    always_comb begin
        st_nxt = st_r;

        // machine cycle prescaler from the oscillator clock
        phase_last = (st_r.phase == MACHINE_LAST);
        if (phase_last) begin
            st_nxt.phase = 4'h0;
        end else begin
            st_nxt.phase = st_r.phase + 4'h1;
        end
        sample_now = (st_r.phase == SAMPLE_PHASE);
        update_now = (st_r.phase == UPDATE_PHASE);
        state_tick = st_r.phase[0];

        baud = baud_sel(st_r.ctrl);
        updn = updn_sel(st_r.ctrl, st_r.mode);
        run = st_r.ctrl[RUN_BIT];

        ////////////////////////////////////////////////////////////////////////////////
        // pin sampling; a pending edge is applied in the next machine cycle
        cnt_edge = st_r.cnt_smp & ~external_count_input;
        trg_edge = st_r.trg_smp & ~trigger_direction_pin;
        if (update_now) begin
            st_nxt.cnt_pend = 1'b0;
            st_nxt.trg_pend = 1'b0;
        end
        if (sample_now) begin
            st_nxt.cnt_smp = external_count_input;
            st_nxt.trg_smp = trigger_direction_pin;
            if (cnt_edge) begin
                st_nxt.cnt_pend = 1'b1;
            end
            if (trg_edge) begin
                st_nxt.trg_pend = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // count tick source
        if (st_r.ctrl[SRC_BIT]) begin
            tick = run & update_now & st_r.cnt_pend;
        end else if (baud) begin
            tick = run & state_tick;
        end else begin
            tick = run & update_now;
        end
        trig = run & update_now & st_r.trg_pend & st_r.ctrl[EXEN_BIT];

        down = updn & ~trigger_direction_pin;
        at_max = (st_r.count == COUNT_MAX);
        at_reload = (st_r.count == st_r.reload);
        ovf = tick & ~down & at_max;
        unf = tick & down & at_reload;
        wrap = ovf | unf;

        ////////////////////////////////////////////////////////////////////////////////
        // software writes to the control register; hardware sets below win
        if (sfr_wr && sfr_addr == CTRL_ADDR) begin
            st_nxt.ctrl = sfr_wdata;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // counting; a software count write in the same cycle wins over this update
        if (tick) begin
            if (down) begin
                if (unf) begin
                    st_nxt.count = COUNT_MAX;
                end else begin
                    st_nxt.count = st_r.count - 16'h0001;
                end
            end else if (ovf) begin
                if (baud || !st_r.ctrl[CPRL_BIT]) begin
                    st_nxt.count = st_r.reload;
                end else begin
                    // capture mode wraps to zero on overflow
                    st_nxt.count = COUNT_RESET;
                end
            end else begin
                st_nxt.count = st_r.count + 16'h0001;
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // flag updates
        if (wrap && !baud) begin
            st_nxt.ctrl[OVF_BIT] = 1'b1;
        end
        if (wrap && updn) begin
            st_nxt.ctrl[EXT_BIT] = ~st_r.ctrl[EXT_BIT];
        end

        ////////////////////////////////////////////////////////////////////////////////
        // trigger edge actions
        // in baud mode an edge only sets the flag, so the pin serves as an extra interrupt
        if (trig && !updn) begin
            st_nxt.ctrl[EXT_BIT] = 1'b1;
            if (!baud) begin
                if (st_r.ctrl[CPRL_BIT]) begin
                    st_nxt.reload = st_r.count;
                end else begin
                    st_nxt.count = st_r.reload;
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // software writes to the data registers
        if (sfr_wr) begin
            case (sfr_addr)
                MODE_ADDR: begin
                    st_nxt.mode = sfr_wdata[1:0];
                end
                RELOAD_LO_ADDR: begin
                    st_nxt.reload[7:0] = sfr_wdata;
                end
                RELOAD_HI_ADDR: begin
                    st_nxt.reload[15:8] = sfr_wdata;
                end
                COUNT_LO_ADDR: begin
                    st_nxt.count[7:0] = sfr_wdata;
                end
                COUNT_HI_ADDR: begin
                    st_nxt.count[15:8] = sfr_wdata;
                end
                default: begin
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////////
        // serial port clock selection
        own_tick = baud & ovf;
        if (st_r.ctrl[RCLK_BIT]) begin
            st_nxt.rx_tick = own_tick;
        end else begin
            st_nxt.rx_tick = other_timer_overflow;
        end
        if (st_r.ctrl[TRANSMIT_CLOCK_SELECT_BIT]) begin
            st_nxt.tx_tick = own_tick;
        end else begin
            st_nxt.tx_tick = other_timer_overflow;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // read data, one cycle after the address
        st_nxt.rdata = read_mux(sfr_addr, st_r);
    end

    // one register stage holds every field; the prescaler phase starts from zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r.ctrl <= CTRL_RESET;
            st_r.mode <= MODE_RESET;
            st_r.reload <= RELOAD_RESET;
            st_r.count <= COUNT_RESET;
            st_r.phase <= 4'h0;
            st_r.cnt_smp <= 1'b0;
            st_r.trg_smp <= 1'b0;
            st_r.cnt_pend <= 1'b0;
            st_r.trg_pend <= 1'b0;
            st_r.rx_tick <= 1'b0;
            st_r.tx_tick <= 1'b0;
            st_r.rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign sfr_rdata = st_r.rdata;
    assign rx_clock_tick = st_r.rx_tick;
    assign tx_clock_tick = st_r.tx_tick;
    // interrupt request level; the external flag is a count bit in up/down mode
    assign irq_src = st_r.ctrl[OVF_BIT] | (st_r.ctrl[EXT_BIT] & ~st_r.mode[UPDN_BIT]);
    assign timer_irq = timer_irq_enable & irq_src;

endmodule

`default_nettype wire

// file: hw/timer2_pkg.sv
// package: register map, field positions, timing counts and state of the timer two block
package timer2_pkg;
    // register addresses in special function register space
    localparam logic [7:0] CTRL_ADDR = 8'hc8;
    localparam logic [7:0] MODE_ADDR = 8'hc9;
    localparam logic [7:0] RELOAD_LO_ADDR = 8'hca;
    localparam logic [7:0] RELOAD_HI_ADDR = 8'hcb;
    localparam logic [7:0] COUNT_LO_ADDR = 8'hcc;
    localparam logic [7:0] COUNT_HI_ADDR = 8'hcd;
    // timer_two_control bit positions
    localparam int unsigned OVF_BIT = 7;
    localparam int unsigned EXT_BIT = 6;
    localparam int unsigned RCLK_BIT = 5;
    localparam int unsigned TRANSMIT_CLOCK_SELECT_BIT = 4;
    localparam int unsigned EXEN_BIT = 3;
    localparam int unsigned RUN_BIT = 2;
    localparam int unsigned SRC_BIT = 1;
    localparam int unsigned CPRL_BIT = 0;
    // timer_two_mode bit positions
    localparam int unsigned OUT_EN_BIT = 1;
    localparam int unsigned UPDN_BIT = 0;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    // oscillator periods per machine cycle and per state time
    localparam int unsigned OSC_PER_MACHINE = 12;
    localparam int unsigned OSC_PER_STATE = 2;
    localparam logic [3:0] MACHINE_LAST = 4'(OSC_PER_MACHINE - 1);
    // phase of the machine cycle at which pins are sampled and the count updates
    localparam logic [3:0] SAMPLE_PHASE = 4'h9;
    localparam logic [3:0] UPDATE_PHASE = 4'h2;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] mode;
        logic [15:0] reload;
        logic [15:0] count;
        logic [3:0] phase;
        logic cnt_smp;
        logic trg_smp;
        logic cnt_pend;
        logic trg_pend;
        logic rx_tick;
        logic tx_tick;
        logic [7:0] rdata;
    } timer2_state_t;
endpackage

// file: test/event_source.sv
// partner model: external count and trigger pin sources
`timescale 1ns/1ps
`default_nettype none

module event_source
(
    input wire logic ref_clk,
    input wire logic cnt_want,
    input wire logic trg_want,
    output logic external_count_input,
    output logic trigger_direction_pin
);
    int hc = 0;
    int ht = 0;
    initial begin
        external_count_input = 1'b1;
        trigger_direction_pin = 1'b1;
    end
    // a level may change only after being held more than one machine cycle
    always @(posedge ref_clk) begin
        hc <= hc + 1;
        ht <= ht + 1;
        if (hc >= 12 && cnt_want != external_count_input) begin
            external_count_input <= cnt_want;
            hc <= 0;
        end
        if (ht >= 12 && trg_want != trigger_direction_pin) begin
            trigger_direction_pin <= trg_want;
            ht <= 0;
        end
    end
endmodule

`default_nettype wire

// file: test/timer2_capture_reload_counter_asserts.sv
// checker: port-level properties of the timer two block
`timescale 1ns/1ps
`default_nettype none

module timer2_checker
    import timer2_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_rdata,
    input wire logic timer_irq_enable,
    input wire logic other_timer_overflow,
    input wire logic timer_irq,
    input wire logic rx_clock_tick,
    input wire logic tx_clock_tick
);
    // shadow of rx select, tx select, trigger enable, run
    logic [3:0] sh_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) sh_r <= 4'h0;
        else if (sfr_wr && sfr_addr == CTRL_ADDR) sh_r <= sfr_wdata[5:2];
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_irq_needs_en: assert property (!timer_irq_enable |-> !timer_irq)
        else $error("irq without enable");
    a_rx_from_other: assert property (!sh_r[3] |=> rx_clock_tick == $past(other_timer_overflow))
        else $error("rx tick not other overflow");
    a_tx_from_other: assert property (!sh_r[2] |=> tx_clock_tick == $past(other_timer_overflow))
        else $error("tx tick not other overflow");
    a_baud_no_flag: assert property ((sh_r[3] || sh_r[2]) && !sh_r[1] && !$past(sfr_wr)
        && $stable(timer_irq_enable) |-> !$rose(timer_irq)) else $error("flag in baud mode");
    a_off_holds_irq: assert property (!sh_r[0] && !$past(sfr_wr) && $stable(timer_irq_enable)
        |-> $stable(timer_irq)) else $error("irq moved while off");
    a_reload_readback: assert property (sfr_wr && sfr_addr == RELOAD_HI_ADDR ##1
        sfr_addr == RELOAD_HI_ADDR |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("reload hi");
    a_mode_upper_zero: assert property (sfr_addr == MODE_ADDR |=> sfr_rdata[7:2] == 6'h00)
        else $error("mode upper bits set");
    a_ticks_together: assert property (sh_r[3] && sh_r[2] |=> rx_clock_tick == tx_clock_tick)
        else $error("baud ticks differ");
endmodule

bind timer2_capture_reload_counter timer2_checker chk_i (.ref_clk(ref_clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata),
    .timer_irq_enable(timer_irq_enable), .other_timer_overflow(other_timer_overflow),
    .timer_irq(timer_irq), .rx_clock_tick(rx_clock_tick), .tx_clock_tick(tx_clock_tick));

`default_nettype wire

// file: test/timer2_capture_reload_counter_bench.sv
// testbench: register-level scenarios for the timer two block
`timescale 1ns/1ps
`default_nettype none

module timer2_capture_reload_counter_bench
    import timer2_pkg::*;
;
    logic ref_clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, timer_irq_enable = 1'b0;
    logic other_timer_overflow = 1'b0, cnt_want = 1'b1, trg_want = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic timer_irq, rx_clock_tick, tx_clock_tick, external_count_input, trigger_direction_pin;
    int failures = 0, n_checks = 0, cyc = 0, i, n;

    timer2_capture_reload_counter dut (.ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata),
        .external_count_input(external_count_input), .trigger_direction_pin(trigger_direction_pin),
        .timer_irq_enable(timer_irq_enable), .other_timer_overflow(other_timer_overflow),
        .timer_irq(timer_irq), .rx_clock_tick(rx_clock_tick), .tx_clock_tick(tx_clock_tick));
    event_source src (.ref_clk(ref_clk), .cnt_want(cnt_want), .trg_want(trg_want),
        .external_count_input(external_count_input), .trigger_direction_pin(trigger_direction_pin));

    initial forever #25 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic pair(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_addr = a;
        repeat (2) @(negedge ref_clk);
        chk(nm, {8'h00, exp}, {8'h00, sfr_rdata});
    endtask
    // irq must appear within lo..hi falling edges
    task automatic wait_irq(input int lo, input int hi);
        for (i = 0; i < 40 && timer_irq !== 1'b1; i++) @(negedge ref_clk);
        chk("irq time", 16'h1, {15'h0, timer_irq === 1'b1 && i >= lo && i <= hi});
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge ref_clk) begin
        cyc <= cyc + 1;
        other_timer_overflow <= (cyc[3:0] == 4'h0);
        if (cyc == 3000) begin
            failures++;
            end_sim;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge ref_clk);
        resetn = 1'b1;
        for (int a = 8'hc8; a <= 8'hce; a++) rdc("reset", 8'(a), 8'h00);
        $display("test reset done");
        timer_irq_enable = 1'b1;
        pair(COUNT_LO_ADDR, 16'hfffe);
        pair(RELOAD_LO_ADDR, 16'h1234);
        wr(CTRL_ADDR, 8'h04);
        wait_irq(13, 24);
        wr(CTRL_ADDR, 8'h80);
        rdc("count lo", COUNT_LO_ADDR, 8'h34);
        rdc("count hi", COUNT_HI_ADDR, 8'h12);
        rdc("ctrl", CTRL_ADDR, 8'h80);
        wr(CTRL_ADDR, 8'h00);
        chk("irq", 16'h0, {15'h0, timer_irq});
        $display("test overflow done");
        pair(COUNT_LO_ADDR, 16'habcd);
        wr(CTRL_ADDR, 8'h0f);
        repeat (3) begin
            cnt_want = 1'b0;
            repeat (30) @(negedge ref_clk);
            cnt_want = 1'b1;
            repeat (30) @(negedge ref_clk);
        end
        trg_want = 1'b0;
        wait_irq(0, 39);
        rdc("reload lo", RELOAD_LO_ADDR, 8'hd0);
        rdc("reload hi", RELOAD_HI_ADDR, 8'hab);
        rdc("count lo", COUNT_LO_ADDR, 8'hd0);
        rdc("ctrl", CTRL_ADDR, 8'h4f);
        wr(CTRL_ADDR, 8'h00);
        trg_want = 1'b1;
        $display("test capture done");
        pair(RELOAD_LO_ADDR, 16'hfffc);
        pair(COUNT_LO_ADDR, 16'hfffc);
        wr(CTRL_ADDR, 8'h35);
        repeat (2) @(negedge ref_clk);
        for (i = 0; i < 40 && rx_clock_tick !== 1'b1; i++) @(negedge ref_clk);
        for (n = 1; n < 40; n++) begin
            @(negedge ref_clk);
            if (rx_clock_tick === 1'b1) break;
        end
        chk("baud period", 16'd8, 16'(n));
        chk("tx tick", 16'h1, {15'h0, tx_clock_tick});
        rdc("ctrl", CTRL_ADDR, 8'h35);
        wr(CTRL_ADDR, 8'h00);
        $display("test baud done");
        wr(MODE_ADDR, 8'h01);
        pair(RELOAD_LO_ADDR, 16'h0000);
        pair(COUNT_LO_ADDR, 16'h0000);
        trg_want = 1'b0;
        repeat (30) @(negedge ref_clk);
        wr(CTRL_ADDR, 8'h04);
        wait_irq(0, 12);
        wr(CTRL_ADDR, 8'hc0);
        rdc("count hi", COUNT_HI_ADDR, 8'hff);
        rdc("ctrl", CTRL_ADDR, 8'hc0);
        wr(CTRL_ADDR, 8'h40);
        chk("irq", 16'h0, {15'h0, timer_irq});
        $display("test up down done");
        end_sim;
    end
endmodule

`default_nettype wire
